// ---- hold_uart_rx.sv ----
// Shared constants and the serial byte receiver of the output hold supervisor
// Behaviour
// RQ1 - Values exchanged as serial data on RXD/TXD
// RQ2 - Link lost: keep driving last received value
// RQ3 - After recovery, wait for fresh value first
// RQ4 - CPU diagnostic error freezes the held output
// RQ5 - Auxiliary supply keeps output with modules removed
// RQ6 - No-fault output high without error, else low
// RQ7 - Diagnostics, supply, module or board loss: low
// RQ8 - Start value comes from configuration switches
// RQ9 - No valid frame within timeout means link lost
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------------
// Package
// ----------------------------------------------------------------------------
package hold_sup_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int BAUD_HZ = 9600;
  localparam int BIT_CYCLES = CLK_HZ / BAUD_HZ;
  localparam int TIMEOUT_MS = 100;
  localparam int TIMEOUT_CYCLES = (CLK_HZ / 1000) * TIMEOUT_MS;
  localparam int VALUE_W = 14;
  localparam int HALF_W = 7;
  localparam int MARK_BIT = 7;
  localparam int TX_FRAME_BITS = 10;
  localparam logic [7:0] REQ_BYTE = 8'h3f;
  localparam logic [13:0] OUT_RESET_VALUE = 14'h0000;
  localparam int SYNC_W = 5;
endpackage

// ----------------------------------------------------------------------------
// Serial byte receiver, 8 data bits, one stop bit
// ----------------------------------------------------------------------------
module hold_uart_rx #(
  parameter int BIT_CYCLES = hold_sup_pkg::BIT_CYCLES
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronised reset, active low
  input wire logic ce, // Clock enable
  input wire logic rxd, // Already synchronised serial line
  output logic [7:0] data, // Received byte
  output logic valid, // One-cycle pulse, byte good
  output logic frame_err // One-cycle pulse, bad stop bit
);
  localparam int CW = $clog2(BIT_CYCLES + 1);

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } rx_state_t;

  rx_state_t st_q;
  logic [CW-1:0] cnt_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q;

  if (BIT_CYCLES < 4) begin : g_chk
    $error("BIT_CYCLES too small for mid-bit sampling");
  end

  // Sequencer; sampling at mid-bit tolerates some baud mismatch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= RX_IDLE;
      cnt_q <= '0;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      valid <= 1'b0;
      frame_err <= 1'b0;
    end else if (ce) begin
      valid <= 1'b0;
      frame_err <= 1'b0;
      case (st_q)
        RX_IDLE: begin
          if (!rxd) begin
            st_q <= RX_START;
            cnt_q <= CW'(BIT_CYCLES / 2);
          end
        end
        RX_START: begin
          if (cnt_q == '0) begin
            cnt_q <= CW'(BIT_CYCLES - 1);
            bit_q <= 3'h0;
            st_q <= rxd ? RX_IDLE : RX_DATA; // Glitch rejected
          end else begin
            cnt_q <= cnt_q - CW'(1);
          end
        end
        RX_DATA: begin
          if (cnt_q == '0) begin
            sh_q <= {rxd, sh_q[7:1]}; // LSB first [RQ1]
            cnt_q <= CW'(BIT_CYCLES - 1);
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              st_q <= RX_STOP;
            end
          end else begin
            cnt_q <= cnt_q - CW'(1);
          end
        end
        RX_STOP: begin
          if (cnt_q == '0) begin
            valid <= rxd;
            frame_err <= !rxd;
            st_q <= RX_IDLE;
          end else begin
            cnt_q <= cnt_q - CW'(1);
          end
        end
        default: st_q <= RX_IDLE;
      endcase
    end
  end

  assign data = sh_q;

  // Checks
  property p_stop_good;
    @(posedge clk) disable iff (!rst_n)
    (ce && st_q == RX_STOP && cnt_q == '0) |=> (valid != frame_err);
  endproperty
  a_stop_good: assert property (p_stop_good) else $error("Stop bit not judged"); // [RQ1]
endmodule // hold_uart_rx

`default_nettype wire

// ---- output_hold_fault_supervisor.sv ----
// Top of the output hold and fault supervisor
`timescale 1ns/100ps
`default_nettype none

module output_hold_fault_supervisor #(
  parameter int BIT_CYCLES = hold_sup_pkg::BIT_CYCLES,
  parameter int TIMEOUT_CYCLES = hold_sup_pkg::TIMEOUT_CYCLES
) (
  input wire logic SYS_CLK, // 10 MHz clock
  input wire logic RESET_N, // Async reset, active low
  input wire logic CE, // Clock enable, freezes state when low
  input wire logic RXD, // Serial data from main processor
  output logic TXD, // Serial data to main processor
  input wire logic CPU_DIAG_ERR, // Main CPU self-diagnostic error
  input wire logic SUPPLY_OK, // Controller supply present
  input wire logic AUX_SUPPLY_OK, // External auxiliary supply present
  input wire logic MAIN_BOARD_PRESENT, // Main board plugged
  input wire logic MODULE_SEATED, // This module plugged in its slot
  input wire logic [13:0] OUTPUT_START_VALUE_SWITCHES, // Configured start value
  output logic [13:0] OUT_VALUE, // Value to the U/I converter
  output logic OUT_ENABLE, // Analog output powered
  output logic LINK_OK, // Serial traffic present
  output logic NO_FAULT_OUTPUT_N // High when no error, low on error
);
  localparam int IW = $clog2(TIMEOUT_CYCLES + 1);
  localparam int BW = $clog2(BIT_CYCLES + 1);

  typedef enum logic [2:0] {
    ST_START = 3'b001,
    ST_UP = 3'b010,
    ST_LOST = 3'b100
  } link_state_t;

  if (TIMEOUT_CYCLES < 2 * BIT_CYCLES * hold_sup_pkg::TX_FRAME_BITS) begin : g_chk
    $error("TIMEOUT_CYCLES shorter than two serial frames");
  end

  // --------------------------------------------------------------------------
  // Reset release and pin synchronisers
  // --------------------------------------------------------------------------
  logic rst_n_q1, rst_n;
  logic [hold_sup_pkg::SYNC_W-1:0] pin_q1, pin_q2;
  logic [13:0] sw_q1, sw_q2;
  logic rxd_q1, rxd_q2;
  logic diag_s, supply_s, aux_s, board_s, seated_s;

  // Release is synchronous so no flop sees a partial reset edge
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_n_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_n_q1 <= 1'b1;
      rst_n <= rst_n_q1;
    end
  end

  // Two flops on every pin except CE; first stage read only by the second
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_q1 <= '0;
      pin_q2 <= '0;
      sw_q1 <= 14'h0000;
      sw_q2 <= 14'h0000;
      rxd_q1 <= 1'b1;
      rxd_q2 <= 1'b1;
    end else if (CE) begin
      pin_q1 <= {CPU_DIAG_ERR, SUPPLY_OK, AUX_SUPPLY_OK, MAIN_BOARD_PRESENT, MODULE_SEATED};
      pin_q2 <= pin_q1;
      sw_q1 <= OUTPUT_START_VALUE_SWITCHES;
      sw_q2 <= sw_q1;
      rxd_q1 <= RXD;
      rxd_q2 <= rxd_q1;
    end
  end

  assign {diag_s, supply_s, aux_s, board_s, seated_s} = pin_q2;

  // --------------------------------------------------------------------------
  // Receiver and value framing
  // --------------------------------------------------------------------------
  logic [7:0] rx_data;
  logic rx_valid, rx_err;
  logic [hold_sup_pkg::HALF_W-1:0] hi_q;
  logic hi_ok_q;
  logic [13:0] word_q;
  logic word_ok_q;

  hold_uart_rx #(
    .BIT_CYCLES(BIT_CYCLES)
  ) u_rx (
    .clk(SYS_CLK),
    .rst_n(rst_n),
    .ce(CE),
    .rxd(rxd_q2),
    .data(rx_data),
    .valid(rx_valid),
    .frame_err(rx_err)
  );

  // Marked high half then low half; a stray low half is dropped
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      hi_q <= '0;
      hi_ok_q <= 1'b0;
      word_q <= 14'h0000;
      word_ok_q <= 1'b0;
    end else if (CE) begin
      word_ok_q <= 1'b0;
      if (rx_err) begin
        hi_ok_q <= 1'b0;
      end else if (rx_valid && rx_data[hold_sup_pkg::MARK_BIT]) begin
        hi_q <= rx_data[hold_sup_pkg::HALF_W-1:0];
        hi_ok_q <= 1'b1;
      end else if (rx_valid && hi_ok_q) begin
        word_q <= {hi_q, rx_data[hold_sup_pkg::HALF_W-1:0]}; // [RQ1]
        word_ok_q <= 1'b1;
        hi_ok_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Link supervision
  // --------------------------------------------------------------------------
  link_state_t st_q;
  logic [IW-1:0] idle_q;
  logic expired;
  logic tx_req;

  assign expired = (idle_q == IW'(TIMEOUT_CYCLES - 1));
  assign tx_req = CE && expired && !word_ok_q && (st_q != ST_UP);

  // Silence counter, cleared by each complete value
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      idle_q <= '0;
    end else if (CE) begin
      if (word_ok_q || expired) begin
        idle_q <= '0; // Restart also paces the re-requests
      end else begin
        idle_q <= idle_q + IW'(1);
      end
    end
  end

  // Link state
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_START;
      LINK_OK <= 1'b0;
    end else if (CE) begin
      case (st_q)
        ST_START, ST_LOST: begin
          if (word_ok_q) begin
            st_q <= ST_UP; // Recovery only on a fresh value [RQ3]
            LINK_OK <= 1'b1;
          end else if (expired) begin
            st_q <= ST_LOST;
          end
        end
        ST_UP: begin
          if (expired && !word_ok_q) begin
            st_q <= ST_LOST; // [RQ9]
            LINK_OK <= 1'b0;
          end
        end
        default: st_q <= ST_START;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Held output
  // --------------------------------------------------------------------------
  logic load_ok;
  assign load_ok = word_ok_q && !diag_s && supply_s;

  // Unpowered output falls to zero; otherwise it moves on fresh data when no diag error and main supply present, or to the switches in ST_START
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      OUT_VALUE <= hold_sup_pkg::OUT_RESET_VALUE;
      OUT_ENABLE <= 1'b0;
    end else if (CE) begin
      OUT_ENABLE <= supply_s || aux_s; // [RQ5]
      if (!supply_s && !aux_s) begin
        OUT_VALUE <= hold_sup_pkg::OUT_RESET_VALUE;
      end else if (load_ok) begin
        OUT_VALUE <= word_q; // Diag error or supply loss blocks this [RQ4] [RQ5]
      end else if (st_q == ST_START) begin
        OUT_VALUE <= sw_q2; // Start value before first data [RQ8]
      end
      // No other branch: the last value stays while traffic is gone [RQ2]
    end
  end

  // --------------------------------------------------------------------------
  // Fault message output
  // --------------------------------------------------------------------------
  logic fault;
  assign fault = diag_s || !supply_s || !seated_s || !board_s;

  // Registered so the pin never glitches between inputs
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      NO_FAULT_OUTPUT_N <= 1'b0;
    end else if (CE) begin
      NO_FAULT_OUTPUT_N <= !fault; // [RQ6] [RQ7]
    end
  end

  // --------------------------------------------------------------------------
  // Request transmitter
  // --------------------------------------------------------------------------
  logic [hold_sup_pkg::TX_FRAME_BITS-1:0] tx_sh_q;
  logic [3:0] tx_bits_q;
  logic [BW-1:0] tx_cnt_q;
  logic tx_busy;

  assign tx_busy = (tx_bits_q != 4'h0);

  // Asks the main processor for the current value while the link is down
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      tx_sh_q <= '1;
      tx_bits_q <= 4'h0;
      tx_cnt_q <= '0;
      TXD <= 1'b1;
    end else if (CE) begin
      if (!tx_busy) begin
        TXD <= 1'b1;
        if (tx_req) begin
          tx_sh_q <= {1'b1, hold_sup_pkg::REQ_BYTE, 1'b0}; // [RQ1] [RQ3]
          tx_bits_q <= 4'(hold_sup_pkg::TX_FRAME_BITS);
          tx_cnt_q <= BW'(BIT_CYCLES - 1);
        end
      end else begin
        TXD <= tx_sh_q[0];
        if (tx_cnt_q == '0) begin
          tx_sh_q <= {1'b1, tx_sh_q[hold_sup_pkg::TX_FRAME_BITS-1:1]};
          tx_bits_q <= tx_bits_q - 4'h1;
          tx_cnt_q <= BW'(BIT_CYCLES - 1);
        end else begin
          tx_cnt_q <= tx_cnt_q - BW'(1);
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!rst_n);

  property p_hold_lost;
    (CE && st_q == ST_LOST && !word_ok_q && (supply_s || aux_s)) |=> $stable(OUT_VALUE);
  endproperty
  a_hold_lost: assert property (p_hold_lost) else $error("Value moved while link lost"); // [RQ2]

  property p_resync;
    (CE && st_q == ST_LOST && load_ok) |=> (st_q == ST_UP && OUT_VALUE == $past(word_q) && LINK_OK);
  endproperty
  a_resync: assert property (p_resync) else $error("Fresh value not taken on recovery"); // [RQ3]

  property p_diag_freeze;
    (diag_s && (supply_s || aux_s) && st_q != ST_START) |=> $stable(OUT_VALUE);
  endproperty
  a_diag_freeze: assert property (p_diag_freeze) else $error("Value moved under diag error"); // [RQ4]

  property p_aux_hold;
    (CE && !supply_s && aux_s && st_q != ST_START) |=> ($stable(OUT_VALUE) && OUT_ENABLE);
  endproperty
  a_aux_hold: assert property (p_aux_hold) else $error("Aux supplied value not held"); // [RQ5]

  property p_fault_low;
    (CE && fault) |=> !NO_FAULT_OUTPUT_N;
  endproperty
  a_fault_low: assert property (p_fault_low) else $error("No-fault output not low"); // [RQ7]

  property p_nofault_high;
    (CE && !fault) ##1 (CE && !fault) |=> NO_FAULT_OUTPUT_N [*1];
  endproperty
  a_nofault_high: assert property (p_nofault_high) else $error("No-fault output not high"); // [RQ6]

  property p_timeout;
    (CE && st_q == ST_UP && expired && !word_ok_q) |=> (st_q == ST_LOST && !LINK_OK);
  endproperty
  a_timeout: assert property (p_timeout) else $error("Timeout did not drop link"); // [RQ9]

  property p_tx_idle;
    (CE && !tx_busy && !tx_req) |=> TXD;
  endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("TXD not idle high"); // [RQ1]

  property p_start_value;
    (CE && st_q == ST_START && !load_ok && (supply_s || aux_s)) |=> (OUT_VALUE == $past(sw_q2));
  endproperty
  a_start_value: assert property (p_start_value) else $error("Start value not shown"); // [RQ8]

  c_lost: cover property (st_q == ST_UP ##1 st_q == ST_LOST);
  c_recover: cover property (st_q == ST_LOST ##1 st_q == ST_UP);
  c_fault: cover property (NO_FAULT_OUTPUT_N ##1 !NO_FAULT_OUTPUT_N);
  c_request: cover property (tx_req);
endmodule // output_hold_fault_supervisor

`default_nettype wire

// ---- hold_main_cpu_model.sv ----
// Main-board processor model on the serial link of the hold supervisor
`timescale 1ns/100ps
`default_nettype none

module hold_main_cpu_model #(
  parameter int BIT_CYCLES = 8
) (
  input wire logic clk, // System clock
  input wire logic txd, // Requests from the module
  output logic rxd // Value frames to the module
);
  logic [7:0] last_req; // Last request byte seen
  int req_count; // Requests seen so far

  // --------------------------------------------------------------------------
  // Frame sender, 8N1 LSB first, line idles high
  // --------------------------------------------------------------------------
  initial rxd = 1'b1;

  // One byte, each bit held BIT_CYCLES edges
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      rxd <= f[i];
      repeat (BIT_CYCLES - 1) @(posedge clk);
    end
  endtask

  // Marked high half first, low half second
  task automatic send_value(input logic [13:0] v);
    send_byte({1'b1, v[13:7]});
    send_byte({1'b0, v[6:0]});
  endtask

  // --------------------------------------------------------------------------
  // Request decoder
  // --------------------------------------------------------------------------
  // Mid-bit sampling: half a bit after the start edge, then one bit apart
  initial begin
    req_count = 0;
    last_req = 8'h00;
    forever begin
      @(negedge txd);
      repeat (BIT_CYCLES / 2) @(posedge clk);
      if (txd === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CYCLES) @(posedge clk);
          last_req[i] = txd;
        end
        repeat (BIT_CYCLES) @(posedge clk);
        req_count++;
      end
    end
  end
endmodule // hold_main_cpu_model

`default_nettype wire

// ---- tb_top.sv ----
// Self-checking testbench of the output hold and fault supervisor
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_errors++; \
  $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end

module tb_top;
  localparam int BC = 8;
  localparam int TO = 200;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic cpu_err = 1'b0;
  logic supply_ok = 1'b1;
  logic aux_ok = 1'b1;
  logic board = 1'b1;
  logic seated = 1'b1;
  logic [13:0] sw = 14'h0000;
  logic rxd, txd, out_en, link_ok, no_fault;
  logic [13:0] out_value;
  int n_errors = 0;
  int n_compared = 0;
  int n;

  // --------------------------------------------------------------------------
  // Clock, design and far side
  // --------------------------------------------------------------------------
  // 10 MHz system clock
  always #50 sys_clk = ~sys_clk;

  output_hold_fault_supervisor #(.BIT_CYCLES(BC), .TIMEOUT_CYCLES(TO)) u_dut (
    .SYS_CLK(sys_clk), .RESET_N(rst_n), .CE(ce), .RXD(rxd), .TXD(txd),
    .CPU_DIAG_ERR(cpu_err), .SUPPLY_OK(supply_ok), .AUX_SUPPLY_OK(aux_ok),
    .MAIN_BOARD_PRESENT(board), .MODULE_SEATED(seated),
    .OUTPUT_START_VALUE_SWITCHES(sw), .OUT_VALUE(out_value), .OUT_ENABLE(out_en),
    .LINK_OK(link_ok), .NO_FAULT_OUTPUT_N(no_fault));

  hold_main_cpu_model #(.BIT_CYCLES(BC)) u_cpu (.clk(sys_clk), .txd(txd), .rxd(rxd));

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  // Start value follows the switches before any traffic
  task automatic t_start();
    @(posedge sys_clk);
    sw <= 14'h1234;
    repeat (6) @(posedge sys_clk);
    `CHK(out_value, 14'h1234)
    `CHK(link_ok, 1'b0)
    `CHK(no_fault, 1'b1)
  endtask

  // Plain value, orphan low half, then a replaced high half back to back
  task automatic t_value();
    u_cpu.send_value(14'h2a5c);
    repeat (4) @(posedge sys_clk);
    `CHK(out_value, 14'h2a5c)
    `CHK(link_ok, 1'b1)
    u_cpu.send_byte(8'h15);
    repeat (4) @(posedge sys_clk);
    `CHK(out_value, 14'h2a5c)
    u_cpu.send_byte(8'hff);
    u_cpu.send_value(14'h0155);
    repeat (4) @(posedge sys_clk);
    `CHK(out_value, 14'h0155)
  endtask

  // Silence: link lost, value held, fresh value asked for, then taken
  task automatic t_lost();
    n = u_cpu.req_count;
    @(posedge sys_clk);
    sw <= 14'h0777;
    repeat (2 * TO + 250) @(posedge sys_clk);
    `CHK(link_ok, 1'b0)
    `CHK(out_value, 14'h0155)
    `CHK(u_cpu.req_count > n, 1'b1)
    `CHK(u_cpu.last_req, 8'h3f)
    u_cpu.send_value(14'h3abc);
    repeat (4) @(posedge sys_clk);
    `CHK(out_value, 14'h3abc)
    `CHK(link_ok, 1'b1)
  endtask

  // Diagnostic error freezes the value and drops the no-fault line
  // Clock enable low first: the error must not be seen until it returns
  task automatic t_diag();
    @(posedge sys_clk);
    ce <= 1'b0;
    cpu_err <= 1'b1;
    repeat (5) @(posedge sys_clk);
    `CHK(no_fault, 1'b1)
    `CHK(out_value, 14'h3abc)
    ce <= 1'b1;
    repeat (5) @(posedge sys_clk);
    `CHK(no_fault, 1'b0)
    u_cpu.send_value(14'h0001);
    repeat (4) @(posedge sys_clk);
    `CHK(out_value, 14'h3abc)
    @(posedge sys_clk);
    cpu_err <= 1'b0;
    repeat (5) @(posedge sys_clk);
    `CHK(no_fault, 1'b1)
  endtask

  // Supply loss and removals with the auxiliary supply present, then no power
  task automatic t_power();
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      supply_ok <= (i != 0);
      seated <= (i != 1);
      board <= (i != 2);
      repeat (5) @(posedge sys_clk);
      `CHK(no_fault, 1'b0)
      `CHK(out_value, 14'h3abc)
      `CHK(out_en, 1'b1)
    end
    @(posedge sys_clk);
    board <= 1'b1;
    supply_ok <= 1'b0;
    aux_ok <= 1'b0;
    repeat (5) @(posedge sys_clk);
    `CHK(out_en, 1'b0)
    `CHK(out_value, 14'h0000)
  endtask

  // Mid-run reset: outputs park, then the start value shows again
  task automatic t_reset();
    @(posedge sys_clk);
    supply_ok <= 1'b1;
    aux_ok <= 1'b1;
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    `CHK(link_ok, 1'b0)
    `CHK(no_fault, 1'b0)
    `CHK(txd, 1'b1)
    rst_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    `CHK(out_value, 14'h0777)
    `CHK(out_en, 1'b1)
    `CHK(no_fault, 1'b1)
  endtask

  // --------------------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // --------------------------------------------------------------------------
  // Single exit point of the run
  task automatic end_sim();
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Far beyond the roughly 1550 cycles the scenarios need
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    $display("Error at %0t: watchdog expired", $time);
    end_sim();
  end

  // Reset, outputs parked, then each scenario in turn
  initial begin
    repeat (5) @(posedge sys_clk);
    `CHK(txd, 1'b1)
    `CHK(no_fault, 1'b0)
    @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    t_start();
    t_value();
    t_lost();
    t_diag();
    t_power();
    t_reset();
    end_sim();
  end
endmodule // tb_top

`default_nettype wire
